// ==== design/dprh_ctrl.sv ====
// Purpose: Power/clock and reset controller answering the debug port's handshakes.
// Assumes: Request pins and other-source inputs are asynchronous to sys_clk_i.
// Notes:   Software sees and steers the controller through three APB registers.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

module dprh_ctrl #(
	parameter int PWRUP_CYCLES = dprh_pkg::PWRUP_CYCLES,
	parameter int PWRDN_CYCLES = dprh_pkg::PWRDN_CYCLES,
	parameter int DRESET_CYCLES = dprh_pkg::DRESET_CYCLES,
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Requests from the debug port, asynchronous
	input wire logic dbg_powerup_request_i,
	input wire logic sys_powerup_request_i,
	input wire logic dbg_reset_request_i,
	// Acknowledges to the debug port
	output logic dbg_powerup_ack_o,
	output logic sys_powerup_ack_o,
	output logic dbg_reset_ack_o,
	// Other power sources per domain, asynchronous
	input wire logic [1:0] other_keep_i,
	input wire logic [1:0] other_pd_req_i,
	output logic [1:0] other_pd_ack_o,
	// Domain power, clock and reset controls
	output logic [1:0] pwr_en_o,
	output logic [1:0] clk_en_o,
	output logic ap_reset_o,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);

	// Counters compare against count minus one, so zero or oversized counts cannot work.
	if (PWRUP_CYCLES < 1 || PWRDN_CYCLES < 1 || DRESET_CYCLES < 1) begin : g_bad_count
		$error("dprh_ctrl: timing counts must be at least one");
	end
	if (PWRUP_CYCLES >= (1 << CNT_W) || PWRDN_CYCLES >= (1 << CNT_W)
		|| DRESET_CYCLES >= (1 << CNT_W)) begin : g_bad_width
		$error("dprh_ctrl: CNT_W too narrow for timing counts");
	end

	localparam logic [CNT_W-1:0] UP_LAST = CNT_W'(PWRUP_CYCLES - 1);
	localparam logic [CNT_W-1:0] DN_LAST = CNT_W'(PWRDN_CYCLES - 1);
	localparam logic [CNT_W-1:0] RS_LAST = CNT_W'(DRESET_CYCLES - 1);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [6:0] sync_a;
	logic [6:0] sync_b;
	logic [1:0] req_s;
	logic rreq_s;
	logic [1:0] keep_s;
	logic [1:0] opd_s;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync_a <= 7'h00;
			sync_b <= 7'h00;
		end else begin
			sync_a <= {other_pd_req_i, other_keep_i, dbg_reset_request_i,
				sys_powerup_request_i, dbg_powerup_request_i};
			sync_b <= sync_a;
		end
	end

	assign req_s = sync_b[1:0];
	assign rreq_s = sync_b[2];
	assign keep_s = sync_b[4:3];
	assign opd_s = sync_b[6:5];

	// ==========================================================
	// Registers: control and event flags
	// ==========================================================
	logic bypass;
	logic rst_en;
	logic ev_illegal;
	logic ev_early_rst;
	logic [1:0] ev_emul;
	logic wr_stb;
	logic rd_stb;
	logic [1:0] emul_pulse;
	logic early_rst_pulse;

	// Writes land on the edge that completes the access, when pready_o is seen high.
	// Reads are captured one edge earlier so that the data stands with pready_o.
	assign wr_stb = psel_i & penable_i & pwrite_i & pready_o;
	assign rd_stb = psel_i & penable_i & ~pwrite_i & ~pready_o;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bypass <= dprh_pkg::CTRL_BYPASS_RESET;
			rst_en <= dprh_pkg::CTRL_RST_EN_RESET;
		end else if (wr_stb && paddr_i == dprh_pkg::CTRL_OFFSET) begin
			bypass <= pwdata_i[dprh_pkg::CTRL_BYPASS_BIT];
			rst_en <= pwdata_i[dprh_pkg::CTRL_RST_EN_BIT];
		end
	end

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ev_illegal <= 1'b0;
			ev_early_rst <= 1'b0;
			ev_emul <= 2'b00;
		end else begin
			if (wr_stb && paddr_i == dprh_pkg::EVENT_OFFSET) begin
				if (pwdata_i[dprh_pkg::EV_ILLEGAL_BIT])
					ev_illegal <= 1'b0;
				if (pwdata_i[dprh_pkg::EV_EARLY_RST_BIT])
					ev_early_rst <= 1'b0;
				ev_emul <= ev_emul & ~pwdata_i[dprh_pkg::EV_EMUL_LSB +: 2];
			end
			if (req_s[dprh_pkg::DOM_SYS] && !req_s[dprh_pkg::DOM_DBG])
				ev_illegal <= 1'b1;
			if (early_rst_pulse)
				ev_early_rst <= 1'b1;
			ev_emul <= (wr_stb && paddr_i == dprh_pkg::EVENT_OFFSET)
				? ((ev_emul & ~pwdata_i[dprh_pkg::EV_EMUL_LSB +: 2]) | emul_pulse)
				: (ev_emul | emul_pulse);
		end
	end

	// ==========================================================
	// Per-domain power handshake
	// ==========================================================
	typedef enum logic [1:0] {DPRH_PD_OFF, DPRH_PD_UP, DPRH_PD_ON, DPRH_PD_DOWN} dprh_pd_t;

	logic [1:0] ack;
	logic [1:0] pwr;
	logic [1:0] clk;
	logic [1:0] up_busy;

	genvar d;
	generate
		for (d = 0; d < dprh_pkg::NUM_DOMAINS; d++) begin : g_dom
			dprh_pd_t state;
			logic [CNT_W-1:0] cnt;
			logic opd_q;

			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					state <= DPRH_PD_OFF;
					cnt <= '0;
					ack[d] <= 1'b0;
					pwr[d] <= 1'b0;
					clk[d] <= 1'b0;
				end else if (bypass) begin
					// Ack follows the request directly; power and clock follow the request or another holder.
					state <= DPRH_PD_OFF;
					ack[d] <= req_s[d];
					pwr[d] <= req_s[d] | keep_s[d];
					clk[d] <= req_s[d] | keep_s[d];
				end else begin
					case (state)
						DPRH_PD_OFF: begin
							ack[d] <= 1'b0;
							pwr[d] <= keep_s[d];
							clk[d] <= keep_s[d];
							if (req_s[d]) begin
								cnt <= '0;
								if (pwr[d] && clk[d])
									state <= DPRH_PD_ON;
								else begin
									pwr[d] <= 1'b1;
									state <= DPRH_PD_UP;
								end
							end
						end
						DPRH_PD_UP: begin
							cnt <= cnt + 1'b1;
							if (cnt == UP_LAST) begin
								clk[d] <= 1'b1;
								state <= DPRH_PD_ON;
							end
						end
						DPRH_PD_ON: begin
							pwr[d] <= 1'b1;
							clk[d] <= 1'b1;
							ack[d] <= req_s[d];
							if (!req_s[d]) begin
								ack[d] <= 1'b0;
								cnt <= '0;
								state <= DPRH_PD_DOWN;
							end
						end
						DPRH_PD_DOWN: begin
							// Ack is already low; a new request is only served after OFF.
							ack[d] <= 1'b0;
							clk[d] <= keep_s[d];
							cnt <= cnt + 1'b1;
							if (cnt == DN_LAST) begin
								pwr[d] <= keep_s[d];
								state <= DPRH_PD_OFF;
							end
						end
						default: state <= DPRH_PD_OFF;
					endcase
				end
			end

			// Other sources always get their handshake; power stays while requested.
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					other_pd_ack_o[d] <= 1'b0;
					opd_q <= 1'b0;
				end else begin
					other_pd_ack_o[d] <= opd_s[d];
					opd_q <= opd_s[d];
				end
			end

			assign emul_pulse[d] = opd_s[d] & ~opd_q & req_s[d];
			assign up_busy[d] = (state == DPRH_PD_UP);
		end
	endgenerate

	// Powering off is only allowed when no request and no other source holds it.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pwr_en_o <= 2'b00;
			clk_en_o <= 2'b00;
			dbg_powerup_ack_o <= 1'b0;
			sys_powerup_ack_o <= 1'b0;
		end else begin
			pwr_en_o <= pwr & ~(opd_s & ~req_s & ~keep_s & ~ack);
			clk_en_o <= clk & ~(opd_s & ~req_s & ~keep_s & ~ack);
			dbg_powerup_ack_o <= ack[dprh_pkg::DOM_DBG];
			sys_powerup_ack_o <= ack[dprh_pkg::DOM_SYS];
		end
	end

	// ==========================================================
	// Debug domain reset handshake
	// ==========================================================
	typedef enum logic [1:0] {DPRH_RS_IDLE, DPRH_RS_HOLD, DPRH_RS_ACK} dprh_rs_t;

	dprh_rs_t rs_state;
	logic [CNT_W-1:0] rs_cnt;
	logic rs_reset;

	assign early_rst_pulse = (rs_state == DPRH_RS_HOLD) & ~rreq_s;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rs_state <= DPRH_RS_IDLE;
			rs_cnt <= '0;
			rs_reset <= 1'b0;
			dbg_reset_ack_o <= 1'b0;
		end else begin
			case (rs_state)
				DPRH_RS_IDLE: begin
					dbg_reset_ack_o <= 1'b0;
					if (rreq_s && rst_en) begin
						rs_cnt <= '0;
						// A domain that is off when asked is not reset.
						rs_reset <= pwr[dprh_pkg::DOM_DBG];
						rs_state <= DPRH_RS_HOLD;
					end
				end
				DPRH_RS_HOLD: begin
					rs_cnt <= rs_cnt + 1'b1;
					if (rs_cnt == RS_LAST) begin
						rs_reset <= 1'b0;
						dbg_reset_ack_o <= 1'b1;
						rs_state <= DPRH_RS_ACK;
					end
				end
				DPRH_RS_ACK: begin
					if (!rreq_s) begin
						dbg_reset_ack_o <= 1'b0;
						rs_state <= DPRH_RS_IDLE;
					end
				end
				default: rs_state <= DPRH_RS_IDLE;
			endcase
		end
	end

	// Only access-port logic is reset; the debug port's own registers are not wired here.
	logic dbg_pwr_q;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ap_reset_o <= 1'b1;
			dbg_pwr_q <= 1'b0;
		end else begin
			// A power rise in bypass or from another holder skips the countdown.
			// The edge term still resets the access port for that case.
			ap_reset_o <= rs_reset | up_busy[dprh_pkg::DOM_DBG]
				| (pwr[dprh_pkg::DOM_DBG] & ~dbg_pwr_q);
			dbg_pwr_q <= pwr[dprh_pkg::DOM_DBG];
		end
	end

	// ==========================================================
	// APB read path
	// ==========================================================
	logic [31:0] rdata;
	logic hit;

	always_comb begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		case (paddr_i)
			dprh_pkg::CTRL_OFFSET: begin
				rdata[dprh_pkg::CTRL_BYPASS_BIT] = bypass;
				rdata[dprh_pkg::CTRL_RST_EN_BIT] = rst_en;
			end
			dprh_pkg::STATUS_OFFSET: begin
				rdata[dprh_pkg::ST_REQ_LSB +: 2] = req_s;
				rdata[dprh_pkg::ST_ACK_LSB +: 2] = ack;
				rdata[dprh_pkg::ST_PWR_LSB +: 2] = pwr;
				rdata[dprh_pkg::ST_CLK_LSB +: 2] = clk;
				rdata[dprh_pkg::ST_RREQ_BIT] = rreq_s;
				rdata[dprh_pkg::ST_RACK_BIT] = dbg_reset_ack_o;
				rdata[dprh_pkg::ST_DRST_BIT] = ap_reset_o;
			end
			dprh_pkg::EVENT_OFFSET: begin
				rdata[dprh_pkg::EV_ILLEGAL_BIT] = ev_illegal;
				rdata[dprh_pkg::EV_EARLY_RST_BIT] = ev_early_rst;
				rdata[dprh_pkg::EV_EMUL_LSB +: 2] = ev_emul;
			end
			default: hit = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle, from a flop.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
			if (rd_stb)
				prdata_o <= rdata;
		end
	end

endmodule : dprh_ctrl

// ==== design/dprh_pkg.sv ====
// Purpose: Shared constants for the debug power and reset handshake controller.
// Assumes: 50 MHz system clock; registers reached over a 32-bit APB slave port.
// Notes:   Domain index 0 is the debug domain, index 1 the system domain.
package dprh_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 20;
	localparam int PWRUP_TIME_NS = 1000;
	localparam int PWRDN_TIME_NS = 400;
	localparam int DRESET_TIME_NS = 200;
	// Least times round up to whole cycles.
	localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRDN_CYCLES = (PWRDN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DRESET_CYCLES = (DRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Domains
	// ==========================================================
	localparam int DOM_DBG = 0;
	localparam int DOM_SYS = 1;
	localparam int NUM_DOMAINS = 2;

	// ==========================================================
	// Register map (byte offsets)
	// ==========================================================
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] EVENT_OFFSET = 8'h08;

	// CTRL fields.
	localparam int CTRL_BYPASS_BIT = 0;
	localparam int CTRL_RST_EN_BIT = 1;
	localparam logic CTRL_BYPASS_RESET = 1'b0;
	localparam logic CTRL_RST_EN_RESET = 1'b1;

	// STATUS fields.
	localparam int ST_REQ_LSB = 0;
	localparam int ST_ACK_LSB = 2;
	localparam int ST_PWR_LSB = 4;
	localparam int ST_CLK_LSB = 6;
	localparam int ST_RREQ_BIT = 8;
	localparam int ST_RACK_BIT = 9;
	localparam int ST_DRST_BIT = 10;

	// EVENT fields, write one to clear.
	localparam int EV_ILLEGAL_BIT = 0;
	localparam int EV_EARLY_RST_BIT = 1;
	localparam int EV_EMUL_LSB = 2;

endpackage : dprh_pkg

// ==== dv/dprh_props.sv ====
// Purpose: Port-level assertions for the handshake controller.
// Assumes: Synchronous reset; request pins pass a two-flop synchroniser.
// Notes: Bound to every dprh_ctrl instance.
`timescale 1ns/1ps

module dprh_props (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Handshake pins
	input wire logic dbg_powerup_request_i,
	input wire logic sys_powerup_request_i,
	input wire logic dbg_reset_request_i,
	input wire logic dbg_powerup_ack_o,
	input wire logic sys_powerup_ack_o,
	input wire logic dbg_reset_ack_o,
	// Domain control
	input wire logic [1:0] other_pd_req_i,
	input wire logic [1:0] other_pd_ack_o,
	input wire logic [1:0] pwr_en_o,
	input wire logic [1:0] clk_en_o,
	input wire logic ap_reset_o,
	// Register bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// =====
	// Power handshakes
	// =====
	acks_reset_low_a: assert property (disable iff (1'b0) rst_i |=>
		!dbg_powerup_ack_o && !sys_powerup_ack_o && !dbg_reset_ack_o) else $error("ack after reset");
	dbg_ack_cause_a: assert property ($rose(dbg_powerup_ack_o) |->
		$past(dbg_powerup_request_i, 2)) else $error("debug ack without request");
	sys_ack_hold_a: assert property ($fell(sys_powerup_ack_o) |->
		!$past(sys_powerup_request_i, 2)) else $error("system ack fell early");
	dbg_ack_drop_a: assert property ($fell(dbg_powerup_request_i) |->
		##[1:6] !dbg_powerup_ack_o) else $error("debug ack stuck high");
	dbg_pwr_held_a: assert property (dbg_powerup_ack_o |->
		pwr_en_o[0] && clk_en_o[0]) else $error("debug ack while unpowered");
	sys_pwr_held_a: assert property (sys_powerup_ack_o |->
		pwr_en_o[1] && clk_en_o[1]) else $error("system ack while unpowered");
	emul_ack_given_a: assert property ($rose(other_pd_req_i[1]) ##1 other_pd_req_i[1] [*4] |->
		other_pd_ack_o[1]) else $error("emulated handshake not answered");

	// =====
	// Debug reset and APB wait state
	// =====
	rst_ack_cause_a: assert property ($rose(dbg_reset_ack_o) |->
		$past(dbg_reset_request_i, 2)) else $error("reset ack without request");
	rst_ack_drop_a: assert property ($fell(dbg_reset_request_i) |->
		##[1:6] !dbg_reset_ack_o) else $error("reset ack stuck high");
	ap_reset_powerup_a: assert property ($rose(pwr_en_o[0]) |->
		ap_reset_o) else $error("no access-port reset at power-up");
	ap_reset_off_a: assert property ($rose(ap_reset_o) |->
		pwr_en_o[0]) else $error("access-port reset while unpowered");
	apb_one_wait_a: assert property (psel_i && penable_i && !pready_o |=>
		pready_o) else $error("bus answer late");

	cover property (sys_powerup_ack_o && dbg_powerup_ack_o);
	cover property (other_pd_ack_o[1] && pwr_en_o[1]);
	cover property ($rose(dbg_reset_ack_o));
endmodule : dprh_props

bind dprh_ctrl dprh_props u_props (.sys_clk_i, .rst_i, .dbg_powerup_request_i,
	.sys_powerup_request_i, .dbg_reset_request_i, .dbg_powerup_ack_o, .sys_powerup_ack_o,
	.dbg_reset_ack_o, .other_pd_req_i, .other_pd_ack_o, .pwr_en_o, .clk_en_o, .ap_reset_o,
	.psel_i, .penable_i, .pready_o);

// ==== dv/dprh_dport.sv ====
// Purpose: Behavioural debug port driving the handshake pins.
// Assumes: Bits 31..26 of its status word hold the handshake pairs.
// Notes: Only its own power-on reset or a write clears its request bits.
`timescale 1ns/1ps

module dprh_dport (
	// Clock and power-on reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Debugger side
	input wire logic wr_i,
	input wire logic [31:0] wdata_i,
	input wire logic ap_go_i,
	output logic [31:0] csr_o,
	output logic ap_fault_o,
	// Handshake pins
	output logic dbg_powerup_request_o,
	output logic sys_powerup_request_o,
	output logic dbg_reset_request_o,
	input wire logic dbg_powerup_ack_i,
	input wire logic sys_powerup_ack_i,
	input wire logic dbg_reset_ack_i
);
	logic [2:0] req;
	logic [2:0] ack_m;
	logic [2:0] ack_s;

	// Always-on flops, so a debug reset cannot clear them.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			req <= 3'h0;
		end else if (wr_i) begin
			req <= {wdata_i[30], wdata_i[28], wdata_i[26]};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		ack_m <= {sys_powerup_ack_i, dbg_powerup_ack_i, dbg_reset_ack_i};
		ack_s <= ack_m;
	end

	assign {sys_powerup_request_o, dbg_powerup_request_o, dbg_reset_request_o} = req;
	assign csr_o = {ack_s[2], req[2], ack_s[1], req[1], ack_s[0], req[0], 26'h0};
	assign ap_fault_o = ap_go_i && !(req[1] && ack_s[1]);
endmodule : dprh_dport

// ==== dv/dprh_ctrl_test.sv ====
// Purpose: Self-checking bench for the handshake controller.
// Assumes: 50 MHz clock; a debug port model drives the request pins.
// Notes: Long power-up count kept so an already-powered answer is visibly quick.
`timescale 1ns/1ps

module dprh_ctrl_test;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, csr, wdat = 32'h0, m;
	logic dreq, sreq, rreq, dack, sack, rack, ap_rst, fault, wr = 1'b0, ap_go = 1'b0;
	logic [1:0] keep = 2'h0, pdreq = 2'h0, pdack, pwr, clk;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	logic [31:0] msk_q[$];
	int seed = 32'hd97c5cd0;
	int bad_count = 0, checks_done = 0, ap_cnt = 0, a0;

	always #10 sys_clk_i = ~sys_clk_i;

	dprh_ctrl #(.PWRUP_CYCLES(40), .PWRDN_CYCLES(4), .DRESET_CYCLES(3)) i_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dbg_powerup_request_i(dreq),
		.sys_powerup_request_i(sreq), .dbg_reset_request_i(rreq), .dbg_powerup_ack_o(dack),
		.sys_powerup_ack_o(sack), .dbg_reset_ack_o(rack), .other_keep_i(keep),
		.other_pd_req_i(pdreq), .other_pd_ack_o(pdack), .pwr_en_o(pwr), .clk_en_o(clk),
		.ap_reset_o(ap_rst), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o));

	dprh_dport i_port (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_i(wr), .wdata_i(wdat),
		.ap_go_i(ap_go), .csr_o(csr), .ap_fault_o(fault), .dbg_powerup_request_o(dreq),
		.sys_powerup_request_o(sreq), .dbg_reset_request_o(rreq), .dbg_powerup_ack_i(dack),
		.sys_powerup_ack_i(sack), .dbg_reset_ack_i(rack));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] x, input logic [31:0] mk);
		exp_q.push_back(x);
		msk_q.push_back(mk);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic port(input logic [31:0] v);
		@(posedge sys_clk_i);
		wr <= 1'b1;
		wdat <= v;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask : port

	task automatic wait_csr(input logic [31:0] mk, input logic [31:0] v, input int lim);
		int n;
		n = 0;
		while ((csr & mk) !== v && n < lim) begin
			@(posedge sys_clk_i);
			n++;
		end
		check(csr & mk, v);
	endtask : wait_csr

	// Results are matched against notes in the order the requests went out.
	always @(posedge sys_clk_i) begin
		if (pready_o === 1'b1 && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			e = exp_q.pop_front();
			check({pslverr_o, prdata_o & m}, e);
		end
		if (ap_rst === 1'b1) ap_cnt <= ap_cnt + 1;
	end

	initial begin
		#(20 * 20000);
		bad_count++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		apb(1'b0, 8'h00, 32'h0, 33'h2, ALL);
		apb(1'b0, 8'h04, 32'h0, 33'h0, ALL);
		apb(1'b1, 8'h0c, $random(seed), 33'h100000000, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, 33'h100000000, ALL);
		ap_go <= 1'b1;
		@(posedge sys_clk_i);
		check(fault, 33'h1);
		port(32'h10000000);
		wait_csr(32'h30000000, 32'h30000000, 90);
		check({pwr[0], clk[0]}, 33'h3);
		check(fault, 33'h0);
		apb(1'b0, 8'h04, 32'h0, 33'h55, 32'h7ff);
		port(32'h50000000);
		wait_csr(ALL, 32'hf0000000, 90);
		apb(1'b0, 8'h04, 32'h0, 33'hff, 32'h7ff);
		keep <= 2'h2;
		port(32'h10000000);
		wait_csr(32'h80000000, 32'h0, 20);
		repeat (30) @(posedge sys_clk_i);
		check(pwr[1], 33'h1);
		port(32'h50000000);
		wait_csr(32'h80000000, 32'h80000000, 12);
		keep <= 2'h0;
		pdreq <= 2'h2;
		repeat (6 + ($random(seed) & 7)) @(posedge sys_clk_i);
		check({pwr[1], clk[1], pdack[1]}, 33'h7);
		pdreq <= 2'h0;
		apb(1'b0, 8'h08, 32'h0, 33'h8, 32'h8);
		apb(1'b1, 8'h08, 32'h8, 33'h0, 32'h0);
		apb(1'b0, 8'h08, 32'h0, 33'h0, 32'h8);
		a0 = ap_cnt;
		port(32'h54000000);
		wait_csr(32'h08000000, 32'h08000000, 40);
		check(ap_cnt > a0, 33'h1);
		check(csr[31:28], 33'hf);
		port(32'h50000000);
		wait_csr(32'h08000000, 32'h0, 20);
		port(32'h0);
		wait_csr(32'ha0000000, 32'h0, 20);
		repeat (20) @(posedge sys_clk_i);
		check({pwr, clk}, 33'h0);
		a0 = ap_cnt;
		port(32'h04000000);
		wait_csr(32'h08000000, 32'h08000000, 40);
		check(ap_cnt == a0, 33'h1);
		check(fault, 33'h1);
		port(32'h0);
		wait_csr(32'h08000000, 32'h0, 20);
		apb(1'b1, 8'h00, 32'h1, 33'h0, 32'h0);
		apb(1'b0, 8'h00, 32'h0, 33'h1, ALL);
		port(32'h14000000);
		wait_csr(32'h20000000, 32'h20000000, 12);
		repeat (20) @(posedge sys_clk_i);
		check(csr[27], 33'h0);
		port(32'h0);
		wait_csr(32'h20000000, 32'h0, 12);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		check({dack, sack, rack}, 33'h0);
		close_out();
	end
endmodule : dprh_ctrl_test
